//--- vic_consts.vh
// Constants of the vectored interrupt controller.
`ifndef VIC_CONSTS_VH
`define VIC_CONSTS_VH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define VIC_NCH        64
`define VIC_CHW        6
`define VIC_LVLW       3
`define VIC_NLVL       8
`define VIC_ADRW       8
`define VIC_FAST_LVLS  3'h2
`define VIC_PRI_FLD    4
`define VIC_PRI_PER_WD 8
`define VIC_ENT_SHIFT  2

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define VIC_A_STAT_LO  8'h00
`define VIC_A_STAT_HI  8'h04
`define VIC_A_CLR_LO   8'h08
`define VIC_A_CLR_HI   8'h0c
`define VIC_A_EN_LO    8'h10
`define VIC_A_EN_HI    8'h14
`define VIC_A_FIQ_ENT  8'h18
`define VIC_A_IRQ_ENT  8'h1c
`define VIC_A_WIN      8'h20
`define VIC_A_PRI0     8'h40
`define VIC_A_PRI7     8'h5c
`define VIC_A_TBL0     8'h60
`define VIC_A_TBL7     8'h7c

// ----------------------------------------
// Reset values, fixed masks and window bit positions
// ----------------------------------------
`define VIC_PRI_RST    3'h7
`define VIC_EN_RST     64'h0000000000000000
`define VIC_RSVD_MASK  64'hfffffffffffff1ff
`define VIC_WIN_VF     6
`define VIC_WIN_VI     14
`define VIC_WIN_IC     8

`endif

//--- vic_core.v
// Vectored, prioritising interrupt controller with register port.
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "vic_consts.vh"

module vic_core (
	input  wire        mclk_i,
	input  wire        reset_n_i,
	input  wire [63:0] src_i,
	input  wire [7:0]  addr_i,
	input  wire [31:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [31:0] rdata_o,
	output reg         fiq_o,
	output reg         irq_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg  [63:0] stat_q;
	reg  [63:0] en_q;
	reg  [2:0]  pri_q [0:63];
	reg  [31:0] tbl_q [0:7];
	reg  [5:0]  fch_q;
	reg  [5:0]  ich_q;
	reg         fval_q;
	reg         ival_q;
	reg  [31:0] fent_q;
	reg  [31:0] ient_q;

	reg  [63:0] clr_d;
	reg  [63:0] stat_d;
	reg  [5:0]  fch_d;
	reg  [5:0]  ich_d;
	reg  [2:0]  flv_d;
	reg  [2:0]  ilv_d;
	reg         fval_d;
	reg         ival_d;
	reg  [31:0] rdata_d;
	wire [63:0] act;
	integer     i;
	integer     j;

	// ----------------------------------------
	// Sticky pending status
	// ----------------------------------------
	always @* begin
		clr_d = 64'h0000000000000000;
		if (wr_i && addr_i == `VIC_A_CLR_LO) begin
			clr_d[31:0] = wdata_i;
		end
		if (wr_i && addr_i == `VIC_A_CLR_HI) begin
			clr_d[63:32] = wdata_i;
		end
		stat_d = ((stat_q & ~clr_d) | src_i) & `VIC_RSVD_MASK;
	end

	assign act = stat_q & en_q;

	// ----------------------------------------
	// Arbitration
	// ----------------------------------------
	always @* begin
		fch_d  = 6'h00;
		ich_d  = 6'h00;
		flv_d  = 3'h7;
		ilv_d  = 3'h7;
		fval_d = 1'b0;
		ival_d = 1'b0;
		for (i = `VIC_NCH - 1; i >= 0; i = i - 1) begin
			if (act[i]) begin
				if (pri_q[i] < `VIC_FAST_LVLS) begin
					if (!fval_d || pri_q[i] <= flv_d) begin
						fval_d = 1'b1;
						flv_d  = pri_q[i];
						fch_d  = i[5:0];
					end
				end else begin
					if (!ival_d || pri_q[i] <= ilv_d) begin
						ival_d = 1'b1;
						ilv_d  = pri_q[i];
						ich_d  = i[5:0];
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Read multiplexer
	// ----------------------------------------
	always @* begin
		rdata_d = 32'h00000000;
		case (addr_i)
			`VIC_A_STAT_LO: rdata_d = stat_q[31:0];
			`VIC_A_STAT_HI: rdata_d = stat_q[63:32];
			`VIC_A_EN_LO:   rdata_d = en_q[31:0];
			`VIC_A_EN_HI:   rdata_d = en_q[63:32];
			`VIC_A_FIQ_ENT: rdata_d = fent_q;
			`VIC_A_IRQ_ENT: rdata_d = ient_q;
			`VIC_A_WIN: begin
				rdata_d[5:0]                    = fch_q;
				rdata_d[`VIC_WIN_VF]            = fval_q;
				rdata_d[`VIC_WIN_IC +: 6]       = ich_q;
				rdata_d[`VIC_WIN_VI]            = ival_q;
			end
			default: begin
				if (addr_i >= `VIC_A_PRI0 && addr_i <= `VIC_A_PRI7) begin
					for (j = 0; j < `VIC_PRI_PER_WD; j = j + 1) begin
						rdata_d[j*`VIC_PRI_FLD +: 3] = pri_q[{addr_i[4:2], j[2:0]}];
					end
				end else if (addr_i >= `VIC_A_TBL0 && addr_i <= `VIC_A_TBL7) begin
					rdata_d = tbl_q[addr_i[4:2]];
				end
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stat_q  <= 64'h0000000000000000;
			en_q    <= `VIC_EN_RST;
			fch_q   <= 6'h00;
			ich_q   <= 6'h00;
			fval_q  <= 1'b0;
			ival_q  <= 1'b0;
			fent_q  <= 32'h00000000;
			ient_q  <= 32'h00000000;
			fiq_o   <= 1'b0;
			irq_o   <= 1'b0;
			rdata_o <= 32'h00000000;
			for (i = 0; i < `VIC_NCH; i = i + 1) begin
				pri_q[i] <= `VIC_PRI_RST;
			end
			for (i = 0; i < `VIC_NLVL; i = i + 1) begin
				tbl_q[i] <= 32'h00000000;
			end
		end else begin
			stat_q <= stat_d;
			fch_q  <= fch_d;
			ich_q  <= ich_d;
			fval_q <= fval_d;
			ival_q <= ival_d;
			fiq_o  <= fval_d;
			irq_o  <= ival_d;
			fent_q <= tbl_q[flv_d] + {24'h000000, fch_d, 2'b00};
			ient_q <= tbl_q[ilv_d] + {24'h000000, ich_d, 2'b00};
			if (rd_i) begin
				rdata_o <= rdata_d;
			end else begin
				rdata_o <= 32'h00000000;
			end
			if (wr_i) begin
				if (addr_i == `VIC_A_EN_LO) begin
					en_q[31:0] <= wdata_i;
				end
				if (addr_i == `VIC_A_EN_HI) begin
					en_q[63:32] <= wdata_i;
				end
				if (addr_i >= `VIC_A_PRI0 && addr_i <= `VIC_A_PRI7) begin
					for (j = 0; j < `VIC_PRI_PER_WD; j = j + 1) begin
						pri_q[{addr_i[4:2], j[2:0]}] <= wdata_i[j*`VIC_PRI_FLD +: 3];
					end
				end
				if (addr_i >= `VIC_A_TBL0 && addr_i <= `VIC_A_TBL7) begin
					tbl_q[addr_i[4:2]] <= wdata_i;
				end
			end
		end
	end

endmodule

//--- vic_cpu_model.sv
// Processor core model counting fast request entries.
`timescale 1ns/100ps
module vic_cpu_model (
	input  wire       mclk_i,
	input  wire       fiq_i,
	input  wire       irq_i,
	output reg  [3:0] takes_o
);
	reg fiq_q = 1'b0;
	initial takes_o = 4'h0;
	always @(posedge mclk_i) begin
		fiq_q <= fiq_i;
		if (fiq_i && !fiq_q) takes_o <= takes_o + 4'h1;
	end
endmodule

//--- vic_core_asserts.sv
// Port assertions of the interrupt controller.
`timescale 1ns/100ps
`include "vic_consts.vh"
module vic_core_chk (
	input wire        mclk_i,
	input wire        reset_n_i,
	input wire [63:0] src_i,
	input wire [7:0]  addr_i,
	input wire [31:0] wdata_i,
	input wire        wr_i,
	input wire        rd_i,
	input wire [31:0] rdata_o,
	input wire        fiq_o,
	input wire        irq_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	property p_idle; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_unm; rd_i && addr_i == 8'h80 |=> rdata_o == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unm");
	property p_rsv; rd_i && addr_i == `VIC_A_STAT_LO |=> rdata_o[11:9] == 3'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("rsv");
	property p_win; rd_i && addr_i == `VIC_A_WIN |=> rdata_o[6] == $past(fiq_o) && rdata_o[14] == $past(irq_o); endproperty
	a_win: assert property (p_win) else $error("win");
	property p_en; wr_i && addr_i == `VIC_A_EN_LO ##1 !wr_i ##1 rd_i && addr_i == `VIC_A_EN_LO |=> rdata_o == $past(wdata_i, 3); endproperty
	a_en: assert property (p_en) else $error("en");
	property p_pri; rd_i && addr_i[7:5] == 3'h2 |=> (rdata_o & 32'h88888888) == 32'h0; endproperty
	a_pri: assert property (p_pri) else $error("pri");
	property p_stk; src_i[3] ##1 rd_i && addr_i == `VIC_A_STAT_LO |=> rdata_o[3]; endproperty
	a_stk: assert property (p_stk) else $error("stk");
	property p_rise; $rose(fiq_o) || $rose(irq_o) |-> $past(|src_i, 2) || $past(wr_i) || $past(wr_i, 2); endproperty
	a_rise: assert property (p_rise) else $error("rise");
	c_fiq: cover property ($rose(fiq_o));
	c_irq: cover property ($rose(irq_o));
	c_win: cover property (rd_i && addr_i == `VIC_A_WIN);
endmodule
bind vic_core vic_core_chk i_vic_core_chk (.*);

//--- vic_core_tb.sv
// Self-checking bench of the interrupt controller.
`timescale 1ns/100ps
`include "vic_consts.vh"
module vic_core_tb;
	reg         mclk_i = 1'b0;
	reg         reset_n_i = 1'b0;
	reg  [63:0] src_i = 64'h0;
	reg  [7:0]  addr_i = 8'h0;
	reg  [31:0] wdata_i = 32'h0;
	reg         wr_i = 1'b0;
	reg         rd_i = 1'b0;
	wire [31:0] rdata_o;
	wire        fiq_o;
	wire        irq_o;
	wire [3:0]  takes;
	integer     err_count = 0;
	integer     tests_run = 0;
	integer     cyc = 0;
	vic_core i_vic_core (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .src_i(src_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fiq_o(fiq_o), .irq_o(irq_o));
	vic_cpu_model i_vic_cpu_model (.mclk_i(mclk_i), .fiq_i(fiq_o), .irq_i(irq_o), .takes_o(takes));
	initial begin
		forever #4 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			err_count = err_count + 1;
			print_verdict;
		end
	end
	task print_verdict;
		if (err_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task rd(input [7:0] a, input [31:0] e);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk($sformatf("reg %h", a), rdata_o, e);
	endtask
	task wait_out(input [63:0] s);
		// Bench picks the source of every channel.
		@(posedge mclk_i);
		src_i <= s;
		repeat (2) @(posedge mclk_i);
		#1;
	endtask
	task t_fiq;
		wr(`VIC_A_PRI0, 32'h77070777);
		wr(`VIC_A_TBL0, 32'h1000);
		wr(`VIC_A_EN_LO, 32'h28);
		rd(`VIC_A_EN_LO, 32'h28);
		wait_out(64'h28);
		chk("fiq", fiq_o, 1);
		rd(`VIC_A_WIN, 32'h43);
		rd(`VIC_A_FIQ_ENT, 32'h100c);
		rd(`VIC_A_STAT_LO, 32'h28);
		src_i <= 64'h0;
		wr(`VIC_A_CLR_LO, 32'h28);
		repeat (2) @(posedge mclk_i);
		#1 chk("fiq clr", fiq_o, 0);
		chk("takes", takes, 1);
	endtask
	task t_irq;
		wr(8'h50, 32'h77777757);
		wr(8'h54, 32'h77777772);
		wr(8'h44, 32'h77777727);
		wr(8'h68, 32'h2000);
		wr(`VIC_A_EN_LO, 32'h200);
		wr(`VIC_A_EN_HI, 32'h102);
		wait_out(64'h0000010200000200);
		chk("irq", irq_o, 1);
		chk("fiq", fiq_o, 0);
		rd(`VIC_A_WIN, 32'h6800);
		rd(`VIC_A_IRQ_ENT, 32'h20a0);
		rd(`VIC_A_STAT_LO, 32'h0);
		wr(`VIC_A_EN_HI, 32'h0);
		repeat (2) @(posedge mclk_i);
		#1 chk("irq mask", irq_o, 0);
	endtask
	initial begin
		repeat (16) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		rd(`VIC_A_PRI0, 32'h77777777);
		rd(8'h80, 32'h0);
		t_fiq;
		t_irq;
		print_verdict;
	end
endmodule
